// file: hw/matrix_slice.sv
// Package of shared types and constants for the bit matrix product unit, and one matrix slice.
// Assumes a single clock domain; all inputs come from logic on the same clock.

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************************
// Shared constants and types
// ****************************************************************************
package bit_matrix_pkg;
  localparam int OPND_W = 64;
  localparam int SLICE_W = 22;
  localparam int NARROW_W = 20;
  localparam int SLICE_ELEMS = 32;
  localparam int SLICES_PER_PIPE = 3;
  localparam int NUM_PIPES = 2;
  localparam int MAX_LEN = 64;
  localparam int CNT_W = 7;
  localparam int COL_W = 5;
  localparam int MID_LO = 20;
  localparam int TOP_LO = 42;
  localparam logic FLAG_RST = 1'h0;

  typedef enum logic [2:0] {
    OP_LOAD_LO = 3'h0,
    OP_LOAD_HI = 3'h1,
    OP_VMUL = 3'h2,
    OP_SMUL = 3'h3,
    OP_CLEAR = 3'h4
  } op_t;

  typedef struct packed {
    op_t op;
    logic [CNT_W-1:0] len;
    logic [OPND_W-1:0] scalar;
  } cmd_t;

  typedef struct packed {
    logic clear;
    logic load_en;
    logic load_pipe;
    logic [COL_W-1:0] col;
  } slice_ctrl_t;

  typedef struct packed {
    logic [OPND_W-1:0] data;
    logic [CNT_W-1:0] index;
    logic pipe;
  } vres_t;

  // Picks the operand share of slice q; the narrow slice gets its two low inputs tied to zero.
  function automatic logic [SLICE_W-1:0] slice_bits(input logic [OPND_W-1:0] d, input int q);
    logic [SLICE_W-1:0] r;
    r = '0;
    if (q == 0) begin
      r = d[OPND_W-1:TOP_LO];
    end else if (q == 1) begin
      r = d[TOP_LO-1:MID_LO];
    end else begin
      r = {d[NARROW_W-1:0], 2'h0};
    end
    return r;
  endfunction
endpackage

// ****************************************************************************
// One matrix slice: 22 stored rows by 32 element columns
// ****************************************************************************
module matrix_slice
  import bit_matrix_pkg::*;
#(
  parameter logic PIPE = 1'h0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire slice_ctrl_t ctrl_i,
  output slice_ctrl_t ctrl_o,
  input wire logic [SLICE_W-1:0] data_i,
  input wire logic [SLICE_W-1:0] operand_i,
  output logic [SLICE_ELEMS-1:0] partial_o
);
  // Storage is held transposed: row k is operand bit k, column is the element of this pipe.
  logic [SLICE_ELEMS-1:0] bt_reg [SLICE_W];

  assign ctrl_o = ctrl_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int k = 0; k < SLICE_W; k++) begin
        bt_reg[k] <= '0;
      end
    end else if (ctrl_i.clear) begin
      for (int k = 0; k < SLICE_W; k++) begin
        bt_reg[k] <= '0;
      end
    end else if (ctrl_i.load_en && ctrl_i.load_pipe == PIPE) begin
      for (int k = 0; k < SLICE_W; k++) begin
        bt_reg[k][ctrl_i.col] <= data_i[k];
      end
    end
  end

  always_comb begin
    partial_o = '0;
    for (int k = 0; k < SLICE_W; k++) begin
      if (operand_i[k]) begin
        partial_o = partial_o ^ bt_reg[k];
      end
    end
  end
endmodule

`default_nettype wire

// file: hw/bit_matrix_product_unit.sv
// Bit matrix product unit: transposing matrix load and AND/XOR product of a scalar or vector.
// Assumes the issue logic and register files run on clk_i and stream vector elements in order.

`timescale 1ns/1ps
`default_nettype none

module bit_matrix_product_unit
  import bit_matrix_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire cmd_t cmd_i,
  input wire logic elem_valid_i,
  output logic elem_ready_o,
  input wire logic [OPND_W-1:0] elem_data_i,
  output logic vres_valid_o,
  output vres_t vres_o,
  output logic sres_valid_o,
  output logic [OPND_W-1:0] sres_data_o,
  output logic matrix_loaded_flag_o
);
  // ****************************************************************************
  // Sequencing
  // ****************************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOAD = 3'h2,
    ST_VMUL = 3'h4
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [CNT_W-1:0] len_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic cmd_take;
  logic elem_take;
  logic last_elem;
  logic start_stream;

  assign cmd_ready_o = (state_reg == ST_IDLE);
  assign elem_ready_o = (state_reg == ST_LOAD) || (state_reg == ST_VMUL);
  assign cmd_take = cmd_valid_i && cmd_ready_o;
  assign elem_take = elem_valid_i && elem_ready_o;
  assign last_elem = (cnt_reg == len_reg - 7'h01);
  assign start_stream = cmd_take && (cmd_i.len != 7'h00) && (cmd_i.len <= 7'(MAX_LEN));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_stream && (cmd_i.op == OP_LOAD_LO || cmd_i.op == OP_LOAD_HI)) begin
          state_next = ST_LOAD;
        end else if (start_stream && cmd_i.op == OP_VMUL) begin
          state_next = ST_VMUL;
        end
      end
      ST_LOAD, ST_VMUL: begin
        if (elem_take && last_elem) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      len_reg <= 7'h00;
      cnt_reg <= 7'h00;
    end else if (start_stream) begin
      len_reg <= cmd_i.len;
      cnt_reg <= 7'h00;
    end else if (elem_take) begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      matrix_loaded_flag_o <= FLAG_RST;
    end else if (state_reg == ST_LOAD && elem_take && last_elem) begin
      matrix_loaded_flag_o <= 1'h1;
    end else if (cmd_take && cmd_i.op == OP_CLEAR) begin
      matrix_loaded_flag_o <= 1'h0;
    end
  end

  // ****************************************************************************
  // Slices
  // ****************************************************************************
  slice_ctrl_t ctrl;
  slice_ctrl_t relay_ctrl [NUM_PIPES];
  logic [OPND_W-1:0] operand;
  logic [SLICE_ELEMS-1:0] partial [NUM_PIPES][SLICES_PER_PIPE];

  always_comb begin
    ctrl.clear = start_stream && (cmd_i.op == OP_LOAD_LO || cmd_i.op == OP_LOAD_HI);
    ctrl.load_en = (state_reg == ST_LOAD) && elem_take;
    ctrl.load_pipe = cnt_reg[0];
    ctrl.col = cnt_reg[COL_W:1];
  end

  assign operand = (state_reg == ST_VMUL) ? elem_data_i : cmd_i.scalar;

  for (genvar p = 0; p < NUM_PIPES; p++) begin : g_pipe
    for (genvar q = 0; q < SLICES_PER_PIPE; q++) begin : g_slice
      if (q == 1) begin : g_relay
        matrix_slice #(.PIPE(1'(p))) matrix_slice_i (
          .clk_i(clk_i),
          .rstn_i(rstn_i),
          .ctrl_i(ctrl),
          .ctrl_o(relay_ctrl[p]),
          .data_i(slice_bits(elem_data_i, q)),
          .operand_i(slice_bits(operand, q)),
          .partial_o(partial[p][q])
        );
      end else begin : g_plain
        matrix_slice #(.PIPE(1'(p))) matrix_slice_i (
          .clk_i(clk_i),
          .rstn_i(rstn_i),
          .ctrl_i(relay_ctrl[p]),
          .ctrl_o(),
          .data_i(slice_bits(elem_data_i, q)),
          .operand_i(slice_bits(operand, q)),
          .partial_o(partial[p][q])
        );
      end
    end
  end

  // ****************************************************************************
  // Result assembly
  // ****************************************************************************
  logic [OPND_W-1:0] product;

  // stored row j drives bit 63-j
  always_comb begin
    product = '0;
    for (int j = 0; j < MAX_LEN; j++) begin
      product[OPND_W-1-j] = partial[j % 2][0][j / 2] ^ partial[j % 2][1][j / 2] ^ partial[j % 2][2][j / 2];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vres_valid_o <= 1'h0;
      vres_o <= '0;
    end else begin
      vres_valid_o <= (state_reg == ST_VMUL) && elem_take;
      if ((state_reg == ST_VMUL) && elem_take) begin
        vres_o.data <= product;
        vres_o.index <= cnt_reg;
        vres_o.pipe <= cnt_reg[0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sres_valid_o <= 1'h0;
      sres_data_o <= '0;
    end else begin
      sres_valid_o <= cmd_take && (cmd_i.op == OP_SMUL);
      if (cmd_take && cmd_i.op == OP_SMUL) begin
        sres_data_o <= product;
      end
    end
  end

  // ****************************************************************************
  // Checks
  // ****************************************************************************
  logic [OPND_W-1:0] shadow_reg [MAX_LEN];
  logic [CNT_W-1:0] out_cnt_reg;
  logic [SLICE_W-1:0] narrow_operand;

  assign narrow_operand = slice_bits(operand, 2);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int j = 0; j < MAX_LEN; j++) begin
        shadow_reg[j] <= '0;
      end
    end else if (ctrl.clear) begin
      for (int j = 0; j < MAX_LEN; j++) begin
        shadow_reg[j] <= '0;
      end
    end else if (ctrl.load_en) begin
      shadow_reg[cnt_reg[COL_W:0]] <= elem_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_cnt_reg <= 7'h00;
    end else if (start_stream) begin
      out_cnt_reg <= 7'h00;
    end else if (vres_valid_o) begin
      out_cnt_reg <= out_cnt_reg + 7'h01;
    end
  end

  function automatic logic [OPND_W-1:0] ref_mul(input logic [OPND_W-1:0] a);
    logic [OPND_W-1:0] r;
    r = '0;
    for (int j = 0; j < MAX_LEN; j++) begin
      r[OPND_W-1-j] = ^(a & shadow_reg[j]);
    end
    return r;
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_loaded_flag_set: assert property ((state_reg == ST_LOAD) && elem_take && last_elem
    |=> matrix_loaded_flag_o)
    else $error("loaded flag not set after load");
  a_loaded_flag_hold: assert property (matrix_loaded_flag_o && !(cmd_take && cmd_i.op == OP_CLEAR)
    |=> matrix_loaded_flag_o)
    else $error("loaded flag dropped without clear");
  a_clear_flag: assert property (cmd_take && cmd_i.op == OP_CLEAR |=> !matrix_loaded_flag_o)
    else $error("clear did not reset loaded flag");
  a_scalar_product: assert property (cmd_take && cmd_i.op == OP_SMUL
    |=> sres_valid_o && sres_data_o == ref_mul($past(cmd_i.scalar)))
    else $error("scalar product wrong");
  a_vector_product: assert property ((state_reg == ST_VMUL) && elem_take
    |=> vres_valid_o && vres_o.data == ref_mul($past(elem_data_i)))
    else $error("vector product wrong");
  a_pipe_parity: assert property (vres_valid_o
    |-> vres_o.index == out_cnt_reg && vres_o.pipe == out_cnt_reg[0])
    else $error("result on wrong pipe");
  a_result_count: assert property ((state_reg == ST_VMUL) && elem_take && last_elem
    |=> vres_valid_o && out_cnt_reg + 7'h01 == len_reg)
    else $error("result count differs from length");
  a_index_in_matrix: assert property (vres_valid_o |-> vres_o.index < len_reg)
    else $error("result outside matrix");
  a_narrow_inputs: assert property (narrow_operand[1:0] == 2'h0)
    else $error("narrow slice low inputs not zero");
  a_relay_copy: assert property (relay_ctrl[0] == ctrl && relay_ctrl[1] == ctrl)
    else $error("relayed control differs");

  c_load_done: cover property ((state_reg == ST_LOAD) && elem_take && last_elem);
  c_vmul_done: cover property ((state_reg == ST_VMUL) && elem_take && last_elem && len_reg == 7'(MAX_LEN));
  c_smul: cover property (cmd_take && cmd_i.op == OP_SMUL && matrix_loaded_flag_o);
  c_clear: cover property (cmd_take && cmd_i.op == OP_CLEAR && matrix_loaded_flag_o);
endmodule

`default_nettype wire

// file: tb/matrix_feeder.sv
// Partner model: the issue side that streams one vector register into the unit.
// Assumes the bench holds start_i for one edge with count_i, slow_i and table_i stable.

`timescale 1ns/1ps
`default_nettype none

module matrix_feeder
  import bit_matrix_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [CNT_W-1:0] count_i,
  input wire logic slow_i,
  input wire logic [63:0][OPND_W-1:0] table_i,
  input wire logic elem_ready_i,
  output logic elem_valid_o,
  output logic [OPND_W-1:0] elem_data_o,
  output logic done_o
);
  logic active_reg;
  logic gap_reg;
  logic [CNT_W-1:0] idx_reg;
  logic [OPND_W-1:0] last_reg;

  // ****************************************************************************
  // Element stream
  // ****************************************************************************
  // in-order exact count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_reg <= 1'h0;
      gap_reg <= 1'h0;
      idx_reg <= '0;
      last_reg <= '0;
    end else if (start_i) begin
      active_reg <= 1'h1;
      gap_reg <= 1'h0;
      idx_reg <= '0;
    end else if (active_reg) begin
      if (elem_valid_o && elem_ready_i) begin
        last_reg <= elem_data_o;
        idx_reg <= idx_reg + 7'h01;
        gap_reg <= slow_i;
        if (idx_reg + 7'h01 == count_i) begin
          active_reg <= 1'h0;
        end
      end else begin
        gap_reg <= 1'h0;
      end
    end
  end

  // inverted idle data
  // Between elements the data line shows the inverse of the last value, never a stale copy.
  assign elem_valid_o = active_reg && !gap_reg;
  assign elem_data_o = elem_valid_o ? table_i[idx_reg[5:0]] : ~last_reg;
  assign done_o = !active_reg;
endmodule

`default_nettype wire

// file: tb/bit_matrix_product_unit_bench.sv
// Self-checking bench for the bit matrix product unit, driving commands and a streaming feeder.
// Assumes the package and both design files are compiled first.

`timescale 1ns/1ps
`default_nettype none

module bit_matrix_product_unit_bench;
  import bit_matrix_pkg::*;
  logic clk, rstn, cmd_valid, cmd_ready, elem_valid, elem_ready, vres_valid, sres_valid, flag, start, slow, done;
  cmd_t cmd;
  vres_t vres;
  logic [63:0] elem_data, sres_data;
  logic [6:0] count;
  logic [63:0][63:0] tbl;
  logic [63:0] bm [64];
  vres_t got_q[$];
  int fail_count, total_checks, cycles;

  bit_matrix_product_unit bit_matrix_product_unit_i (.clk_i(clk), .rstn_i(rstn), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_i(cmd), .elem_valid_i(elem_valid), .elem_ready_o(elem_ready),
    .elem_data_i(elem_data), .vres_valid_o(vres_valid), .vres_o(vres), .sres_valid_o(sres_valid),
    .sres_data_o(sres_data), .matrix_loaded_flag_o(flag));
  matrix_feeder matrix_feeder_i (.clk_i(clk), .rstn_i(rstn), .start_i(start), .count_i(count),
    .slow_i(slow), .table_i(tbl), .elem_ready_i(elem_ready), .elem_valid_o(elem_valid),
    .elem_data_o(elem_data), .done_o(done));

  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  function automatic logic [63:0] mask(int n);
    return ~(64'hFFFF_FFFF_FFFF_FFFF >> n);
  endfunction

  function automatic logic [63:0] pat(int s, int k, int n);
    return mask(n) & ({2{32'h9E37_79B9 * (s + 7 * k + 1)}} ^ (64'h8000_0000_0000_0000 >> k));
  endfunction

  function automatic logic [63:0] prod(logic [63:0] a, int n);
    logic [63:0] r;
    r = '0;
    for (int j = 0; j < n; j++) r[63-j] = ^(a & bm[j]);
    return r;
  endfunction

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({63'h0, got}, {63'h0, exp});
  endtask

  task automatic send_cmd(input op_t op, input logic [6:0] n, input logic [63:0] s, input logic go);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, len: n, scalar: s};
    start <= go;
    count <= n;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    start <= 1'b0;
  endtask

  task automatic wait_done();
    @(negedge clk);
    while (!(done === 1'b1 && cmd_ready === 1'b1)) @(negedge clk);
  endtask

  // ****************************************************************************
  // Scenarios
  // ****************************************************************************
  task automatic t_reset();
    chk_bit(flag, 1'b0);
    chk_bit(cmd_ready, 1'b1);
    chk_bit(vres_valid, 1'b0);
    chk_bit(sres_valid, 1'b0);
    chk_word(sres_data, 64'h0);
  endtask

  task automatic t_load(input op_t op, input int n, input logic sl, input int s);
    for (int k = 0; k < 64; k++) begin
      tbl[k] = (k < n) ? pat(s, k, n) : 64'hFFFF_FFFF_FFFF_FFFF;
      bm[k] = (k < n) ? tbl[k] : 64'h0;
    end
    slow = sl;
    send_cmd(op, 7'(n), 64'h0, 1'b1);
    wait_done();
    chk_bit(flag, 1'b1);
  endtask

  task automatic t_smul(input int s, input int n);
    logic [63:0] a;
    a = pat(s, 0, n);
    send_cmd(OP_SMUL, 7'(n), a, 1'b0);
    @(negedge clk);
    chk_bit(sres_valid, 1'b1);
    chk_word(sres_data, prod(a, n));
    @(negedge clk);
    chk_bit(sres_valid, 1'b0);
  endtask

  task automatic t_vmul(input int n, input logic sl, input int s);
    for (int k = 0; k < 64; k++) tbl[k] = pat(s, k, n);
    slow = sl;
    got_q.delete();
    send_cmd(OP_VMUL, 7'(n), 64'h0, 1'b1);
    wait_done();
    repeat (2) @(negedge clk);
    chk_word(64'(got_q.size()), 64'(n));
    for (int k = 0; k < got_q.size(); k++) begin
      chk_word(got_q[k].data, prod(tbl[k], n));
      chk_word(64'(got_q[k].index), 64'(k));
      chk_bit(got_q[k].pipe, k[0]);
    end
  endtask

  task automatic t_clear();
    chk_bit(flag, 1'b1);
    send_cmd(OP_CLEAR, 7'h00, 64'h0, 1'b0);
    @(negedge clk);
    chk_bit(flag, 1'b0);
  endtask

  task automatic t_bad_vl();
    send_cmd(OP_LOAD_LO, 7'h00, 64'h0, 1'b0);
    @(negedge clk);
    chk_bit(elem_ready, 1'b0);
    send_cmd(OP_LOAD_HI, 7'h41, 64'h0, 1'b0);
    @(negedge clk);
    chk_bit(cmd_ready, 1'b1);
    chk_bit(flag, 1'b0);
  endtask

  // ****************************************************************************
  // Run control
  // ****************************************************************************
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (vres_valid === 1'b1) got_q.push_back(vres);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    start = 1'b0;
    slow = 1'b0;
    count = '0;
    tbl = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_load(OP_LOAD_LO, 64, 1'h0, 1);
    t_smul(2, 64);
    t_smul(3, 64);
    t_vmul(64, 1'h0, 4);
    t_clear();
    t_bad_vl();
    t_load(OP_LOAD_HI, 5, 1'h1, 5);
    t_smul(6, 5);
    t_vmul(5, 1'h1, 7);
    t_load(OP_LOAD_LO, 1, 1'h0, 8);
    t_smul(9, 1);
    wrap_up();
  end
endmodule

`default_nettype wire
